// ---- core/iob_bridge.sv ----
`include "iob_map.svh"

module iob_bridge
   import iob_pkg::*;
   (
   // Clock and reset
   input  wire logic                            clock,
   input  wire logic                            reset,
   // System side
   input  wire logic                            io_request,
   input  wire logic [`IOB_SEL_W-1:0]           io_sel,
   output logic                                 io_grant,
   // Peripheral side
   input  wire logic [`IOB_NUM_SEL-1:0][1:0]    sel_cycle_type,
   output logic [`IOB_NUM_SEL-1:0]              periph_select,
   output logic                                 buffer_enable,
   // Counters
   input  wire logic [`IOB_NUM_CNT-1:0][`IOB_CNT_W-1:0] cnt_reload,
   output logic [1:0]                           timer_event,
   output logic                                 baud_clock_out,
   // Keyboard serial link
   input  wire logic                            kb_rxd,
   input  wire logic                            kb_tx_start,
   input  wire logic [7:0]                      kb_tx_data,
   output logic                                 kb_txd,
   output logic                                 kb_tx_busy,
   output iob_kb_rx_s                           kb_rx,
   // Interrupts
   input  wire logic [`IOB_NUM_IRQ-1:0]         irq_source,
   input  wire logic [1:0]                      irq_edge_clear,
   input  wire logic [`IOB_NUM_IRQ-1:0]         irq_mask_normal,
   input  wire logic [`IOB_NUM_IRQ-1:0]         irq_mask_fast,
   output iob_irq_s                             irq,
   // General control pins
   input  wire logic [`IOB_NUM_GPIO-1:0]        gpio_dir,
   input  wire logic [`IOB_NUM_GPIO-1:0]        gpio_out,
   input  wire logic [`IOB_NUM_GPIO-1:0]        gpio_pin_i,
   output logic [`IOB_NUM_GPIO-1:0]             gpio_pin_o,
   output logic [`IOB_NUM_GPIO-1:0]             gpio_pin_oe,
   output logic [`IOB_NUM_GPIO-1:0]             gpio_in
   );

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   // ******************************************************************
   // Counters
   // ******************************************************************
   logic [`IOB_NUM_CNT-1:0] cnt_expire;

   genvar gi;
   generate
      for (gi = 0; gi < `IOB_NUM_CNT; gi++) begin : g_cnt
         iob_counter #(.W(`IOB_CNT_W)) u_cnt (
            .clock  (clock),
            .reset  (reset),
            .reload (cnt_reload[gi]),
            .expire (cnt_expire[gi])
         );
      end
   endgenerate

   logic kb_tick;
   assign kb_tick = cnt_expire[`IOB_CNT_KB];

   always_ff @(posedge clock) begin
      if (reset) begin
         timer_event    <= 2'b00;
         baud_clock_out <= 1'b0;
      end else begin
         timer_event <= cnt_expire[1:0];
         if (cnt_expire[`IOB_CNT_BAUD])
            baud_clock_out <= ~baud_clock_out;
      end
   end

   // ******************************************************************
   // Peripheral cycle
   // ******************************************************************
   iob_per_state_e        per_state_r;
   logic [`IOB_CYC_W-1:0] cyc_cnt_r;
   logic [`IOB_CYC_W-1:0] cyc_len;
   logic [1:0]            cyc_type;

   always_comb begin
      cyc_type = 2'b00;
      if (io_sel < `IOB_SEL_W'(`IOB_NUM_SEL))
         cyc_type = sel_cycle_type[io_sel];
      unique case (cyc_type)
         2'b00: cyc_len = `IOB_CYC_LEN0;
         2'b01: cyc_len = `IOB_CYC_LEN1;
         2'b10: cyc_len = `IOB_CYC_LEN2;
         2'b11: cyc_len = `IOB_CYC_LEN3;
      endcase
   end

   // The grant is a single pulse; a new cycle waits for the request to fall so
   // that a request still high after the grant is never taken twice.
   always_ff @(posedge clock) begin
      if (reset) begin
         per_state_r   <= IOB_PER_IDLE;
         cyc_cnt_r     <= '0;
         io_grant      <= 1'b0;
         periph_select <= '0;
         buffer_enable <= 1'b0;
      end else begin
         unique case (per_state_r)
            IOB_PER_IDLE: begin
               io_grant <= 1'b0;
               if (io_request) begin
                  cyc_cnt_r     <= cyc_len;
                  periph_select <= `IOB_NUM_SEL'(1 << io_sel);
                  buffer_enable <= 1'b1;
                  per_state_r   <= IOB_PER_ACTIVE;
               end
            end
            IOB_PER_ACTIVE: begin
               buffer_enable <= io_request;
               if (cyc_cnt_r != '0)
                  cyc_cnt_r <= cyc_cnt_r - 1'b1;
               else if (io_request) begin
                  io_grant    <= 1'b1;
                  per_state_r <= IOB_PER_GRANT;
               end
            end
            IOB_PER_GRANT: begin
               io_grant      <= 1'b0;
               periph_select <= '0;
               buffer_enable <= 1'b0;
               per_state_r   <= IOB_PER_RELEASE;
            end
            IOB_PER_RELEASE: begin
               if (!io_request)
                  per_state_r <= IOB_PER_IDLE;
            end
         endcase
      end
   end

   // ******************************************************************
   // Interrupts
   // ******************************************************************
   logic [1:0]                edge_prev_r;
   logic [1:0]                edge_latch_r;
   logic [1:0]                edge_rise;
   logic [`IOB_NUM_IRQ-1:0]   irq_status_nxt;

   assign edge_rise      = irq_source[`IOB_NUM_IRQ-1:`IOB_NUM_LEVEL] & ~edge_prev_r;
   assign irq_status_nxt = {edge_latch_r | edge_rise, irq_source[`IOB_NUM_LEVEL-1:0]};

   always_ff @(posedge clock) begin
      if (reset) begin
         edge_prev_r  <= 2'b00;
         edge_latch_r <= 2'b00;
      end else begin
         edge_prev_r  <= irq_source[`IOB_NUM_IRQ-1:`IOB_NUM_LEVEL];
         edge_latch_r <= (edge_latch_r & ~irq_edge_clear) | edge_rise;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         irq <= '0;
      end else begin
         irq.status <= irq_status_nxt;
         irq.normal <= |(irq_status_nxt & irq_mask_normal);
         irq.fast   <= |(irq_status_nxt & irq_mask_fast);
      end
   end

   // ******************************************************************
   // General control pins
   // ******************************************************************
   always_ff @(posedge clock) begin
      if (reset) begin
         gpio_pin_o  <= '0;
         gpio_pin_oe <= '0;
         gpio_in     <= '0;
      end else begin
         gpio_pin_o  <= gpio_out;
         gpio_pin_oe <= gpio_dir;
         gpio_in     <= gpio_pin_i;
      end
   end

   // ******************************************************************
   // Keyboard transmitter
   // ******************************************************************
   logic [10:0] tx_shift_r;
   logic [3:0]  tx_tick_r;
   logic [3:0]  tx_bits_r;

   always_ff @(posedge clock) begin
      if (reset) begin
         tx_shift_r <= '1;
         tx_tick_r  <= 4'h0;
         tx_bits_r  <= 4'h0;
         kb_txd     <= 1'b1;
         kb_tx_busy <= 1'b0;
      end else if (!kb_tx_busy) begin
         if (kb_tx_start) begin
            tx_shift_r <= {2'b11, kb_tx_data, 1'b0};
            kb_txd     <= 1'b0;
            tx_tick_r  <= 4'h0;
            tx_bits_r  <= 4'h1;
            kb_tx_busy <= 1'b1;
         end
      end else if (kb_tick) begin
         tx_tick_r <= tx_tick_r + 1'b1;
         if (tx_tick_r == `IOB_KB_OVS_LAST) begin
            if (tx_bits_r == `IOB_KB_FRAME) begin
               kb_tx_busy <= 1'b0;
               kb_txd     <= 1'b1;
            end else begin
               kb_txd    <= tx_shift_r[tx_bits_r];
               tx_bits_r <= tx_bits_r + 1'b1;
            end
         end
      end
   end

   // ******************************************************************
   // Keyboard receiver
   // ******************************************************************
   iob_rx_state_e rx_state_r;
   logic [3:0]    rx_tick_r;
   logic [3:0]    rx_bits_r;
   logic [7:0]    rx_shift_r;
   logic          rx_err_r;

   always_ff @(posedge clock) begin
      if (reset) begin
         rx_state_r <= IOB_RX_IDLE;
         rx_tick_r  <= 4'h0;
         rx_bits_r  <= 4'h0;
         rx_shift_r <= 8'h00;
         rx_err_r   <= 1'b0;
         kb_rx      <= '0;
      end else begin
         kb_rx.valid <= 1'b0;
         if (kb_tick) begin
            unique case (rx_state_r)
               IOB_RX_IDLE: begin
                  rx_tick_r <= 4'h0;
                  if (!kb_rxd)
                     rx_state_r <= IOB_RX_START;
               end
               IOB_RX_START: begin
                  if (kb_rxd)
                     rx_state_r <= IOB_RX_IDLE;
                  else if (rx_tick_r == `IOB_KB_HALF_LAST) begin
                     rx_tick_r  <= 4'h0;
                     rx_bits_r  <= 4'h0;
                     rx_err_r   <= 1'b0;
                     rx_state_r <= IOB_RX_DATA;
                  end else
                     rx_tick_r <= rx_tick_r + 1'b1;
               end
               IOB_RX_DATA: begin
                  rx_tick_r <= rx_tick_r + 1'b1;
                  if (rx_tick_r == `IOB_KB_OVS_LAST) begin
                     rx_shift_r <= {kb_rxd, rx_shift_r[7:1]};
                     if (rx_bits_r == `IOB_KB_DATA_BITS - 1'b1) begin
                        rx_bits_r  <= 4'h0;
                        rx_state_r <= IOB_RX_STOP;
                     end else
                        rx_bits_r <= rx_bits_r + 1'b1;
                  end
               end
               IOB_RX_STOP: begin
                  rx_tick_r <= rx_tick_r + 1'b1;
                  if (rx_tick_r == `IOB_KB_OVS_LAST) begin
                     if (rx_bits_r == `IOB_KB_STOP_BITS - 1'b1) begin
                        kb_rx.data        <= rx_shift_r;
                        kb_rx.frame_error <= rx_err_r | ~kb_rxd;
                        kb_rx.valid       <= 1'b1;
                        rx_state_r        <= IOB_RX_IDLE;
                     end else begin
                        rx_err_r  <= rx_err_r | ~kb_rxd;
                        rx_bits_r <= rx_bits_r + 1'b1;
                     end
                  end
               end
            endcase
         end
      end
   end

   // ******************************************************************
   // Checks
   // ******************************************************************
   property p_grant_cause;
      io_grant |-> $past(io_request) && $past(cyc_cnt_r == '0)
                   && $past(per_state_r == IOB_PER_ACTIVE);
   endproperty
   a_grant_cause: assert property (p_grant_cause) else $error("grant without done cycle");

   property p_grant_waits;
      per_state_r == IOB_PER_ACTIVE && cyc_cnt_r == '0 && !io_request |=> !io_grant;
   endproperty
   a_grant_waits: assert property (p_grant_waits) else $error("grant while request off");

   property p_buffers_off;
      per_state_r == IOB_PER_ACTIVE && !io_request |=> !buffer_enable;
   endproperty
   a_buffers_off: assert property (p_buffers_off) else $error("buffers on while suspended");

   property p_cycle_runs;
      per_state_r == IOB_PER_ACTIVE && cyc_cnt_r != '0
         |=> cyc_cnt_r == `IOB_CYC_W'($past(cyc_cnt_r) - 1'b1);
   endproperty
   a_cycle_runs: assert property (p_cycle_runs) else $error("cycle count stalled");

   property p_select_onehot;
      $onehot0(periph_select);
   endproperty
   a_select_onehot: assert property (p_select_onehot) else $error("two selects active");

   property p_fast_mask;
      ##1 irq.fast == $past(|(irq_status_nxt & irq_mask_fast));
   endproperty
   a_fast_mask: assert property (p_fast_mask) else $error("fast interrupt wrong");

   property p_edge_sticky;
      $rose(irq_source[`IOB_NUM_LEVEL]) ##1 !irq_edge_clear[0] |=> irq.status[`IOB_NUM_LEVEL];
   endproperty
   a_edge_sticky: assert property (p_edge_sticky) else $error("edge source lost");

   property p_false_start;
      rx_state_r == IOB_RX_START && kb_tick && kb_rxd |=> rx_state_r == IOB_RX_IDLE;
   endproperty
   a_false_start: assert property (p_false_start) else $error("short start not dropped");

   sequence s_tx_accept;
      kb_tx_start && !kb_tx_busy;
   endsequence
   property p_tx_start_bit;
      s_tx_accept |=> !kb_txd && kb_tx_busy;
   endproperty
   a_tx_start_bit: assert property (p_tx_start_bit) else $error("no start bit");

   property p_baud_toggle;
      cnt_expire[`IOB_CNT_BAUD] |=> baud_clock_out != $past(baud_clock_out);
   endproperty
   a_baud_toggle: assert property (p_baud_toggle) else $error("baud pin not toggled");

   property p_gpio_dir;
      ##1 gpio_pin_oe == $past(gpio_dir);
   endproperty
   a_gpio_dir: assert property (p_gpio_dir) else $error("pin direction wrong");
endmodule : iob_bridge

// ---- core/iob_map.svh ----
`ifndef IOB_MAP_SVH
`define IOB_MAP_SVH
// Operation
// - Keyboard frame: one start bit, eight data bits, two stop bits, both directions.
// - Keyboard link samples and shifts at sixteen times the bit rate.
// - Transmit and receive share one rate taken from the third counter.
// - A start bit low for under half a bit is discarded.
// - Second counter drives a dedicated baud clock output pin.
// - Six general pins, each programmable as input or output.
// - Separate normal and fast interrupt outputs, each with own mask.
// - Sixteen interrupt sources: fourteen level sensed, two edge sensed.
// - Peripheral bus offers four distinct access cycle lengths.
// - Seven peripheral selects, each assignable to any cycle length.
// - Bridge raises io_grant when the peripheral access has completed.
// - While request is withdrawn, buffers are off and the cycle keeps running.
// - Suspended cycle ends only when both master and slave timing are met.
// - Four 16-bit counters: first two general timers, the second also the baud clock, the third the keyboard rate, the fourth unused.

// ******************************************************************
// Peripheral bus
// ******************************************************************
`define IOB_NUM_SEL      7
`define IOB_SEL_W        3
`define IOB_CYC_W        8
`define IOB_CYC_LEN0     8'h04
`define IOB_CYC_LEN1     8'h08
`define IOB_CYC_LEN2     8'h0C
`define IOB_CYC_LEN3     8'h14

// ******************************************************************
// Counters, pins and interrupts
// ******************************************************************
`define IOB_NUM_CNT      4
`define IOB_CNT_W        16
`define IOB_CNT_BAUD     1
`define IOB_CNT_KB       2
`define IOB_NUM_GPIO     6
`define IOB_NUM_IRQ      16
`define IOB_NUM_LEVEL    14

// ******************************************************************
// Keyboard serial link
// ******************************************************************
`define IOB_KB_OVS_LAST  4'hF
`define IOB_KB_HALF_LAST 4'h7
`define IOB_KB_DATA_BITS 4'h8
`define IOB_KB_STOP_BITS 4'h2
`define IOB_KB_FRAME     4'hB
`endif

// ---- core/iob_pkg.sv ----
package iob_pkg;
   typedef enum logic [1:0] {
      IOB_PER_IDLE   = 2'b00,
      IOB_PER_ACTIVE = 2'b01,
      IOB_PER_GRANT  = 2'b11,
      IOB_PER_RELEASE = 2'b10
   } iob_per_state_e;

   typedef enum logic [1:0] {
      IOB_RX_IDLE  = 2'b00,
      IOB_RX_START = 2'b01,
      IOB_RX_DATA  = 2'b11,
      IOB_RX_STOP  = 2'b10
   } iob_rx_state_e;

   typedef struct packed {
      logic [7:0] data;
      logic       valid;
      logic       frame_error;
   } iob_kb_rx_s;

   typedef struct packed {
      logic [15:0] status;
      logic        normal;
      logic        fast;
   } iob_irq_s;
endpackage : iob_pkg

// ---- core/iob_counter.sv ----
module iob_counter
   #(parameter int W = 16)
   (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         reset,
   // Period control, period is reload plus one cycles
   input  wire logic [W-1:0] reload,
   // One-cycle pulse at each expiry
   output logic              expire
   );
   logic [W-1:0] count_r;

   always_ff @(posedge clock) begin
      if (reset) begin
         count_r <= '0;
         expire  <= 1'b0;
      end else if (count_r == '0) begin
         count_r <= reload;
         expire  <= 1'b1;
      end else begin
         count_r <= count_r - 1'b1;
         expire  <= 1'b0;
      end
   end
endmodule : iob_counter

// ---- tb/iob_sys_master.sv ----
`include "iob_map.svh"

module iob_sys_master
   import iob_pkg::*;
   (
   // Clock
   input  wire logic                  clock,
   // Bridge handshake
   input  wire logic                  io_grant,
   output logic                       io_request,
   output logic [`IOB_SEL_W-1:0]      io_sel
   );
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      io_request = 1'b0;
      io_sel     = 3'h7;
   end

   // One access; a DMA is mimicked by dropping the request at drop_at for drop_len cycles.
   // The latency counts rising edges from the taking edge to the grant edge, both included.
   task automatic access(input logic [2:0] sel, input int drop_at, input int drop_len,
                         output int lat);
      int n;
      n = 0;
      lat = -1;
      // The bridge takes no new cycle until it has seen the request low on a rising edge.
      repeat (2) @(negedge clock);
      io_request = 1'b1;
      io_sel     = sel;
      while (lat < 0 && n < 200) begin
         @(posedge clock);
         n++;
         @(negedge clock);
         if (io_grant === 1'b1) begin
            lat = n;
         end else if (n == drop_at) begin
            io_request = 1'b0;
         end else if (n == drop_at + drop_len) begin
            io_request = 1'b1;
         end
      end
      // The select is not left showing its last value, so a stale decode cannot pass.
      io_request = 1'b0;
      io_sel     = ~sel;
   endtask : access
endmodule : iob_sys_master

// ---- tb/testbench.sv ----
`include "iob_map.svh"

module testbench
   import iob_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int BIT_CYC = 32;
   logic                       clock = 1'b0;
   logic                       reset;
   logic                       io_request;
   logic [2:0]                 io_sel;
   logic                       io_grant;
   logic [6:0][1:0]            sel_cycle_type;
   logic [6:0]                 periph_select;
   logic                       buffer_enable;
   logic [3:0][15:0]           cnt_reload;
   logic [1:0]                 timer_event;
   logic                       baud_clock_out;
   logic                       kb_rxd;
   logic                       kb_tx_start;
   logic [7:0]                 kb_tx_data;
   logic                       kb_txd;
   logic                       kb_tx_busy;
   iob_kb_rx_s                 kb_rx;
   logic [15:0]                irq_source;
   logic [1:0]                 irq_edge_clear;
   logic [15:0]                irq_mask_normal;
   logic [15:0]                irq_mask_fast;
   iob_irq_s                   irq;
   logic [5:0]                 gpio_dir;
   logic [5:0]                 gpio_out;
   logic [5:0]                 gpio_pin_i;
   logic [5:0]                 gpio_pin_o;
   logic [5:0]                 gpio_pin_oe;
   logic [5:0]                 gpio_in;
   int                         err_count = 0;
   int                         checked = 0;

   always #25 clock = ~clock;

   iob_sys_master partner (.clock(clock), .io_grant(io_grant), .io_request(io_request),
                           .io_sel(io_sel));

   iob_bridge DUT (.clock(clock), .reset(reset), .io_request(io_request), .io_sel(io_sel),
      .io_grant(io_grant), .sel_cycle_type(sel_cycle_type), .periph_select(periph_select),
      .buffer_enable(buffer_enable), .cnt_reload(cnt_reload), .timer_event(timer_event),
      .baud_clock_out(baud_clock_out), .kb_rxd(kb_rxd), .kb_tx_start(kb_tx_start),
      .kb_tx_data(kb_tx_data), .kb_txd(kb_txd), .kb_tx_busy(kb_tx_busy), .kb_rx(kb_rx),
      .irq_source(irq_source), .irq_edge_clear(irq_edge_clear),
      .irq_mask_normal(irq_mask_normal), .irq_mask_fast(irq_mask_fast), .irq(irq),
      .gpio_dir(gpio_dir), .gpio_out(gpio_out), .gpio_pin_i(gpio_pin_i),
      .gpio_pin_o(gpio_pin_o), .gpio_pin_oe(gpio_pin_oe), .gpio_in(gpio_in));

   // ********************
   // Checking
   // ********************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic print_verdict;
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict

   function automatic int cyc_len(input logic [1:0] t);
      case (t)
         2'h0: return `IOB_CYC_LEN0;
         2'h1: return `IOB_CYC_LEN1;
         2'h2: return `IOB_CYC_LEN2;
         default: return `IOB_CYC_LEN3;
      endcase
   endfunction : cyc_len

   // ********************
   // Scenarios
   // ********************
   task automatic sc_periph;
      int s;
      int lat;
      for (s = 0; s < 8; s++) begin
         partner.access(s[2:0], 0, 0, lat);
         check(16'(lat), 16'(cyc_len(s < 7 ? sel_cycle_type[s] : 2'h0) + 2), "lat");
         check(periph_select, (s < 7) ? (7'h01 << s) : 7'h00, "select");
         @(negedge clock);
         check({io_grant, periph_select}, 16'h0000, "after grant");
      end
      sel_cycle_type[1] = 2'h3;
      partner.access(3'h1, 0, 0, lat);
      check(16'(lat), 16'(`IOB_CYC_LEN3 + 2), "relen");
   endtask : sc_periph

   task automatic sc_dma;
      int lat;
      fork
         partner.access(3'h3, 3, 4, lat);
         begin
            repeat (7) @(negedge clock);
            check({io_grant, buffer_enable}, 16'h0000, "buffers off");
            check(periph_select, 7'h08, "cycle held");
         end
      join
      check(16'(lat), 16'(`IOB_CYC_LEN3 + 2), "short dma");
      partner.access(3'h0, 2, 12, lat);
      check(16'(lat >= 14 && lat <= 15), 16'h0001, "long dma");
   endtask : sc_dma

   task automatic gap_of(input int w, output int g);
      logic prev;
      int   n;
      int   hits;
      n = 0;
      hits = 0;
      g = -1;
      prev = baud_clock_out;
      while (hits < 2 && n < 100) begin
         @(negedge clock);
         n++;
         if (w < 2 ? timer_event[w] === 1'b1 : baud_clock_out !== prev) begin
            if (hits == 1) g = n;
            hits++;
            n = 0;
         end
         prev = baud_clock_out;
      end
   endtask : gap_of

   task automatic sc_counters;
      int g;
      int w;
      for (w = 0; w < 3; w++) begin
         gap_of(w, g);
         check(16'(g), (w == 0) ? 16'h0005 : 16'h0004, "period");
      end
   endtask : sc_counters

   task automatic sc_kb_tx;
      logic [10:0] frame;
      int          i;
      frame = {2'b11, 8'h3C, 1'b0};
      kb_tx_data = 8'h3C;
      kb_tx_start = 1'b1;
      @(negedge clock);
      kb_tx_start = 1'b0;
      check({kb_txd, kb_tx_busy}, 16'h0001, "tx start");
      repeat (BIT_CYC / 2) @(negedge clock);
      for (i = 0; i < 11; i++) begin
         check(kb_txd, frame[i], "tx bit");
         kb_tx_data = 8'hFF;
         kb_tx_start = (i == 3);
         repeat (BIT_CYC) @(negedge clock);
      end
      kb_tx_start = 1'b0;
      check({kb_txd, kb_tx_busy}, 16'h0002, "tx done");
   endtask : sc_kb_tx

   task automatic sc_kb_rx(input logic [7:0] b, input logic stop2, input int low_ticks);
      logic [10:0] frame;
      logic        got;
      int          i;
      frame = {stop2, 1'b1, b, 1'b0};
      got = 1'b0;
      fork
         if (low_ticks > 0) begin
            kb_rxd = 1'b0;
            repeat (low_ticks * 2) @(negedge clock);
            kb_rxd = 1'b1;
         end else begin
            for (i = 0; i < 11; i++) begin
               kb_rxd = frame[i];
               repeat (BIT_CYC) @(negedge clock);
            end
            kb_rxd = 1'b1;
         end
         repeat (12 * BIT_CYC) begin
            @(negedge clock);
            if (kb_rx.valid === 1'b1 && !got) begin
               got = 1'b1;
               check({kb_rx.data, 7'h00, kb_rx.frame_error}, {b, 7'h00, ~stop2}, "rx");
            end
         end
      join
      check(got, low_ticks == 0, "rx valid");
   endtask : sc_kb_rx

   task automatic sc_irq;
      int i;
      for (i = 0; i < 14; i++) begin
         irq_source = 16'h0001 << i;
         irq_mask_normal = irq_source;
         irq_mask_fast = ~irq_source;
         @(negedge clock);
         check(irq.status, 16'h0001 << i, "level");
         check({irq.normal, irq.fast}, 16'h0002, "outputs");
      end
      irq_mask_normal = 16'h0000;
      irq_mask_fast = 16'hC000;
      for (i = 0; i < 2; i++) begin
         irq_source = 16'h0000;
         @(negedge clock);
         irq_source = 16'h4000 << i;
         @(negedge clock);
         irq_source = 16'h0000;
         repeat (2) @(negedge clock);
         check(irq.status, 16'h4000 << i, "edge latch");
         check({irq.normal, irq.fast}, 16'h0001, "fast");
         irq_edge_clear = 2'h1 << i;
         @(negedge clock);
         irq_edge_clear = 2'h0;
         @(negedge clock);
         check(irq.status, 16'h0000, "cleared");
         check(16'(irq.fast), 16'h0000, "cleared fast");
      end
   endtask : sc_irq

   task automatic sc_gpio;
      int i;
      for (i = 0; i < 2; i++) begin
         gpio_dir = i ? 6'h15 : 6'h2A;
         gpio_out = ~gpio_dir;
         gpio_pin_i = gpio_dir;
         @(negedge clock);
         check({gpio_pin_oe, gpio_pin_o}, {gpio_dir, ~gpio_dir}, "pins");
         check(gpio_in, gpio_dir, "pin in");
      end
   endtask : sc_gpio

   // ********************
   // Sequence
   // ********************
   initial begin
      reset = 1'b1;
      sel_cycle_type = {2'h2, 2'h1, 2'h0, 2'h3, 2'h2, 2'h1, 2'h0};
      cnt_reload = {16'h0007, 16'h0001, 16'h0003, 16'h0004};
      kb_rxd = 1'b1;
      kb_tx_start = 1'b0;
      kb_tx_data = 8'h00;
      irq_source = 16'h0000;
      irq_edge_clear = 2'h0;
      irq_mask_normal = 16'h0000;
      irq_mask_fast = 16'h0000;
      gpio_dir = 6'h00;
      gpio_out = 6'h00;
      gpio_pin_i = 6'h00;
      repeat (16) @(negedge clock);
      check({io_grant, buffer_enable, periph_select, kb_txd, kb_tx_busy}, 16'h0002, "reset");
      reset = 1'b0;
      sc_periph();
      sc_dma();
      sc_counters();
      sc_kb_tx();
      sc_kb_rx(8'hA5, 1'b1, 0);
      sc_kb_rx(8'h5A, 1'b0, 0);
      sc_kb_rx(8'h00, 1'b1, 6);
      sc_irq();
      sc_gpio();
      print_verdict();
   end

   // Cuts a hang well beyond the under two thousand cycles the sequence needs.
   initial begin
      #(50 * 10000);
      err_count++;
      print_verdict();
   end
endmodule : testbench
